// [src/ist_slave.sv]
`include "ist_map.svh"
// Function
// RULE_01 - data bytes are eight bits, msb first, only after own address is acked
// RULE_02 - receiver drives low acknowledge after eight data bits
// RULE_03 - transmitter releases sda when master gives no acknowledge
// RULE_04 - received bytes land in data register; transmit bytes come from it
// RULE_05 - receiving slave drives its transmit-acknowledge bit on ninth clock
// RULE_06 - transmitter samples master ack; sends more only on ack, else waits stop
// RULE_07 - after address match scl held until data write or dummy read
// RULE_08 - time-out counter starts on address match, cleared by scl falling edge
// RULE_09 - time-out occurs when gap since last scl fall exceeds period
// RULE_10 - time-out monitoring stops on stop condition
// RULE_11 - on overflow counter halts, enable clears, flag sets
// RULE_12 - time-out raises the shared i2c interrupt
// RULE_13 - time-out resets slave logic and control register 1 only
// RULE_14 - time-out flag stays set until software clears it
// RULE_15 - period is (field+1) times 32 sub-clock cycles, tick is sub clock / 32
// RULE_16 - enable at bit 7, flag at bit 6, both reset to zero
// RULE_17 - counter advances only while time-out enable is set
// RULE_18 - seven address bits msb first compared with own address; match flags
// RULE_19 - eighth bit captured as master read flag
// RULE_20 - matching address acknowledged low on ninth bit
// RULE_21 - start is sda falling while scl high
module ist_slave (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire ist_pkg::ist_axi_req_type axi_req,
  output      ist_pkg::ist_axi_rsp_type axi_rsp,
  input  wire logic                 scl_i,
  output      logic                 scl_o,
  output      logic                 scl_oe_n,
  input  wire logic                 sda_i,
  output      logic                 sda_o,
  output      logic                 sda_oe_n,
  input  wire logic                 low_speed_clock,
  output      logic                 i2c_irq
);
  import ist_pkg::*;

  ist_state_all_type s;
  ist_state_all_type next_s;

  logic       scl_n;
  logic       sda_n;
  logic       sub_n;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_ev;
  logic       stop_ev;
  logic       tick;
  logic       wr;
  logic       rd;
  logic [7:0] wa;
  logic [7:0] ra;
  logic [7:0] wb;
  logic       wr_data;
  logic       rd_data;

  always_comb begin
    next_s = s;
    next_s.irq = 1'b0;
    // pin synchronisers, level moves once stages two and three agree
    next_s.scl_s = {s.scl_s[1:0], scl_i};
    next_s.sda_s = {s.sda_s[1:0], sda_i};
    next_s.sub_s = {s.sub_s[1:0], low_speed_clock};
    scl_n = (s.scl_s[1] == s.scl_s[2]) ? s.scl_s[2] : s.scl_q;
    sda_n = (s.sda_s[1] == s.sda_s[2]) ? s.sda_s[2] : s.sda_q;
    sub_n = (s.sub_s[1] == s.sub_s[2]) ? s.sub_s[2] : s.sub_q;
    next_s.scl_q = scl_n;
    next_s.sda_q = sda_n;
    next_s.sub_q = sub_n;
    scl_rise = scl_n & ~s.scl_q;
    scl_fall = ~scl_n & s.scl_q;
    start_ev = s.scl_q & scl_n & s.sda_q & ~sda_n; // [RULE_21]
    stop_ev  = s.scl_q & scl_n & ~s.sda_q & sda_n;
    // sub clock divided by 32 gives the time-out tick
    tick = 1'b0;
    if (sub_n & ~s.sub_q) begin
      next_s.sub_div = s.sub_div + 5'h01;
      tick = (s.sub_div == 5'(`IST_SUB_DIV - 1)); // [RULE_15]
    end

    // axi4-lite slave: both address and data taken in one cycle
    wr = s.rsp.awready & s.rsp.wready & axi_req.awvalid & axi_req.wvalid;
    rd = s.rsp.arready & axi_req.arvalid;
    wa = {axi_req.awaddr[7:2], 2'b00};
    ra = {axi_req.araddr[7:2], 2'b00};
    wb = axi_req.wdata[7:0];
    wr_data = wr & axi_req.wstrb[0] & (wa == `IST_OFS_DATA);
    rd_data = rd & (ra == `IST_OFS_DATA);
    next_s.rsp.awready = 1'b0;
    next_s.rsp.wready = 1'b0;
    next_s.rsp.arready = 1'b0;
    if (axi_req.awvalid & axi_req.wvalid & ~s.rsp.awready & ~s.rsp.bvalid) begin
      next_s.rsp.awready = 1'b1;
      next_s.rsp.wready = 1'b1;
    end
    if (s.rsp.bvalid & axi_req.bready) begin
      next_s.rsp.bvalid = 1'b0;
    end
    if (axi_req.arvalid & ~s.rsp.arready & ~s.rsp.rvalid) begin
      next_s.rsp.arready = 1'b1;
    end
    if (s.rsp.rvalid & axi_req.rready) begin
      next_s.rsp.rvalid = 1'b0;
    end
    if (wr) begin
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp = `IST_RESP_OKAY;
      if (axi_req.wstrb[0]) begin
        case (wa)
          `IST_OFS_DATA:  next_s.data_reg = wb; // [RULE_04]
          `IST_OFS_ADDR:  next_s.own_addr = wb[6:0];
          `IST_OFS_CTRL0: next_s.ctrl0 = wb;
          `IST_OFS_CTRL1: begin
            next_s.slave_tx_select = wb[`IST_C1_HTX];
            next_s.tx_ack_bit = wb[`IST_C1_TX_ACK_BIT];
          end
          `IST_OFS_TOC: begin
            next_s.to_en = wb[`IST_TOC_EN]; // [RULE_16]
            next_s.to_sel = wb[5:0];
            if (!wb[`IST_TOC_FLAG]) begin
              next_s.to_flag = 1'b0; // [RULE_14]
            end
          end
          default: next_s.rsp.bresp = `IST_RESP_SLV;
        endcase
      end
    end
    if (rd) begin
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rresp = `IST_RESP_OKAY;
      case (ra)
        `IST_OFS_DATA:  next_s.rsp.rdata = {24'h000000, s.data_reg};
        `IST_OFS_ADDR:  next_s.rsp.rdata = {25'h0000000, s.own_addr};
        `IST_OFS_CTRL0: next_s.rsp.rdata = {24'h000000, s.ctrl0};
        `IST_OFS_CTRL1: next_s.rsp.rdata = {25'h0000000, s.addr_match_flag, s.bus_busy_flag, s.slave_tx_select,
                                            s.tx_ack_bit, s.master_read_flag, 1'b0, s.rx_ack_flag};
        `IST_OFS_TOC:   next_s.rsp.rdata = {24'h000000, s.to_en, s.to_flag, s.to_sel};
        default: begin
          next_s.rsp.rdata = 32'h00000000;
          next_s.rsp.rresp = `IST_RESP_SLV;
        end
      endcase
    end

    // bus protocol engine
    case (s.st)
      IST_IDLE: ;
      IST_ADDR: begin
        if (scl_rise) begin
          next_s.shift = {s.shift[6:0], sda_n}; // [RULE_18]
          next_s.bitcnt = s.bitcnt + 4'h1;
        end else if (scl_fall && s.bitcnt == `IST_BYTE_BITS) begin
          if (s.shift[7:1] == s.own_addr) begin
            next_s.addr_match_flag = 1'b1; // [RULE_18]
            next_s.master_read_flag = s.shift[0]; // [RULE_19]
            next_s.sda_oe_n = 1'b0; // [RULE_20]
            next_s.to_run = 1'b1; // [RULE_08]
            next_s.to_cnt = 7'h00;
            next_s.irq = 1'b1;
            next_s.st = IST_ADDR_ACK;
          end else begin
            next_s.st = IST_WAIT_STOP;
          end
        end
      end
      IST_ADDR_ACK: begin
        if (scl_fall) begin
          next_s.sda_oe_n = 1'b1;
          next_s.scl_oe_n = 1'b0; // [RULE_07]
          next_s.st = IST_HOLD;
        end
      end
      IST_HOLD: begin
        if (s.slave_tx_select && wr_data) begin
          next_s.shift = wb; // [RULE_01]
          next_s.sda_oe_n = wb[7];
          next_s.bitcnt = 4'h0;
          next_s.scl_oe_n = 1'b1; // [RULE_07]
          next_s.st = IST_TX;
        end else if (!s.slave_tx_select && rd_data) begin
          next_s.bitcnt = 4'h0;
          next_s.scl_oe_n = 1'b1; // [RULE_07]
          next_s.st = IST_RX;
        end
      end
      IST_TX: begin
        if (scl_fall) begin
          if (s.bitcnt == 4'h7) begin
            next_s.sda_oe_n = 1'b1;
            next_s.st = IST_TX_ACK;
          end else begin
            next_s.shift = {s.shift[6:0], 1'b0}; // [RULE_01]
            next_s.sda_oe_n = s.shift[6];
            next_s.bitcnt = s.bitcnt + 4'h1;
          end
        end
      end
      IST_TX_ACK: begin
        if (scl_rise) begin
          next_s.rx_ack_flag = sda_n; // [RULE_06]
        end else if (scl_fall) begin
          next_s.irq = 1'b1;
          if (!s.rx_ack_flag) begin
            next_s.scl_oe_n = 1'b0; // [RULE_06]
            next_s.st = IST_HOLD;
          end else begin
            next_s.st = IST_WAIT_STOP; // [RULE_03]
          end
        end
      end
      IST_RX: begin
        if (scl_rise) begin
          next_s.shift = {s.shift[6:0], sda_n}; // [RULE_01]
          next_s.bitcnt = s.bitcnt + 4'h1;
        end else if (scl_fall && s.bitcnt == `IST_BYTE_BITS) begin
          next_s.data_reg = s.shift; // [RULE_04]
          next_s.sda_oe_n = s.tx_ack_bit; // [RULE_05] [RULE_02]
          next_s.irq = 1'b1;
          next_s.st = IST_RX_ACK;
        end
      end
      IST_RX_ACK: begin
        if (scl_fall) begin
          next_s.sda_oe_n = 1'b1;
          next_s.bitcnt = 4'h0;
          next_s.st = IST_RX;
        end
      end
      IST_WAIT_STOP: next_s.sda_oe_n = 1'b1; // [RULE_03]
      default: next_s.st = IST_IDLE;
    endcase

    if (start_ev) begin
      next_s.st = IST_ADDR;
      next_s.bitcnt = 4'h0;
      next_s.bus_busy_flag = 1'b1;
      next_s.addr_match_flag = 1'b0;
      next_s.sda_oe_n = 1'b1;
      next_s.scl_oe_n = 1'b1;
    end else if (stop_ev) begin
      next_s.st = IST_IDLE;
      next_s.bus_busy_flag = 1'b0;
      next_s.addr_match_flag = 1'b0;
      next_s.to_run = 1'b0; // [RULE_10]
      next_s.sda_oe_n = 1'b1;
      next_s.scl_oe_n = 1'b1;
    end
    if (!s.ctrl0[`IST_C0_EN]) begin
      next_s.st = IST_IDLE;
      next_s.to_run = 1'b0;
      next_s.sda_oe_n = 1'b1;
      next_s.scl_oe_n = 1'b1;
    end

    // time-out monitor
    if (scl_fall) begin
      next_s.to_cnt = 7'h00; // [RULE_08]
      // prescaler restarts too, so a full period must pass after each fall
      next_s.sub_div = 5'h00; // [RULE_09]
    end else if (s.to_run && s.to_en && tick) begin // [RULE_17]
      if (s.to_cnt >= {1'b0, s.to_sel}) begin // [RULE_09] [RULE_15]
        next_s.to_run = 1'b0; // [RULE_11]
        next_s.to_en = 1'b0; // [RULE_11]
        next_s.to_flag = 1'b1; // [RULE_11] [RULE_14]
        next_s.irq = 1'b1; // [RULE_12]
        next_s.st = IST_IDLE; // [RULE_13]
        next_s.sda_oe_n = 1'b1;
        next_s.scl_oe_n = 1'b1;
        next_s.tx_ack_bit = 1'b0;
        next_s.slave_tx_select = 1'b0;
        next_s.master_read_flag = 1'b0;
        next_s.rx_ack_flag = 1'b0;
        next_s.bus_busy_flag = 1'b0;
        next_s.addr_match_flag = 1'b0;
        next_s.bitcnt = 4'h0;
      end else begin
        next_s.to_cnt = s.to_cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.scl_s <= 3'h7;
      s.sda_s <= 3'h7;
      s.scl_q <= 1'b1;
      s.sda_q <= 1'b1;
      s.st <= IST_IDLE;
      s.ctrl0 <= `IST_RST_REG;
      s.scl_oe_n <= 1'b1;
      s.sda_oe_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign axi_rsp  = s.rsp;
  assign scl_oe_n = s.scl_oe_n;
  assign sda_oe_n = s.sda_oe_n;
  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign i2c_irq  = s.irq;
endmodule // ist_slave

// [shared/ist_map.svh]
`ifndef IST_MAP_SVH
`define IST_MAP_SVH
`define IST_OFS_DATA   8'h00
`define IST_OFS_ADDR   8'h04
`define IST_OFS_CTRL0  8'h08
`define IST_OFS_CTRL1  8'h0c
`define IST_OFS_TOC    8'h10
`define IST_TOC_EN     7
`define IST_TOC_FLAG   6
`define IST_C1_RX_ACK_FLAG    0
`define IST_C1_SRW     2
`define IST_C1_TX_ACK_BIT    3
`define IST_C1_HTX     4
`define IST_C1_HBB     5
`define IST_C1_ADDR_MATCH_FLAG    6
`define IST_C0_EN      0
`define IST_RST_REG    8'h00
`define IST_SUB_DIV    32
`define IST_BYTE_BITS  4'h8
`define IST_RESP_OKAY  2'b00
`define IST_RESP_SLV   2'b10
`endif

// [shared/ist_pkg.sv]
package ist_pkg;
  typedef enum logic [3:0] {
    IST_IDLE      = 4'b0000,
    IST_ADDR      = 4'b0001,
    IST_ADDR_ACK  = 4'b0011,
    IST_HOLD      = 4'b0010,
    IST_TX        = 4'b0110,
    IST_TX_ACK    = 4'b0111,
    IST_RX        = 4'b0101,
    IST_RX_ACK    = 4'b0100,
    IST_WAIT_STOP = 4'b1100
  } ist_state_type;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } ist_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ist_axi_rsp_type;

  typedef struct packed {
    logic [2:0]    scl_s;
    logic [2:0]    sda_s;
    logic [2:0]    sub_s;
    logic          scl_q;
    logic          sda_q;
    logic          sub_q;
    ist_state_type st;
    logic [7:0]    shift;
    logic [3:0]    bitcnt;
    logic [7:0]    data_reg;
    logic [6:0]    own_addr;
    logic [7:0]    ctrl0;
    logic          tx_ack_bit;
    logic          slave_tx_select;
    logic          master_read_flag;
    logic          rx_ack_flag;
    logic          bus_busy_flag;
    logic          addr_match_flag;
    logic          to_en;
    logic          to_flag;
    logic [5:0]    to_sel;
    logic          to_run;
    logic [6:0]    to_cnt;
    logic [4:0]    sub_div;
    logic          scl_oe_n;
    logic          sda_oe_n;
    logic          irq;
    ist_axi_rsp_type rsp;
  } ist_state_all_type;
endpackage

// [verif/ist_checker.sv]
module ist_checker (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire ist_pkg::ist_axi_req_type axi_req,
  input wire ist_pkg::ist_axi_rsp_type axi_rsp,
  input wire logic                     scl_i,
  input wire logic                     scl_o,
  input wire logic                     scl_oe_n,
  input wire logic                     sda_i,
  input wire logic                     sda_o,
  input wire logic                     sda_oe_n,
  input wire logic                     low_speed_clock,
  input wire logic                     i2c_irq
);
  import ist_pkg::*;
  wire logic tk = (axi_req.awvalid && axi_rsp.awready) || (axi_req.arvalid && axi_rsp.arready);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wtake;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  property p_open; scl_o == 1'b0 && sda_o == 1'b0; endproperty
  a_open: assert property (p_open) else $error("pin driven high");
  property p_pulse; i2c_irq |=> !i2c_irq; endproperty
  a_pulse: assert property (p_pulse) else $error("irq too long");
  property p_sda; $changed(sda_oe_n) |-> !scl_i; endproperty
  a_sda: assert property (p_sda) else $error("sda moved, scl high");
  property p_hold; !scl_oe_n |-> sda_oe_n; endproperty
  a_hold: assert property (p_hold) else $error("sda driven in stretch");
  property p_rel; $rose(scl_oe_n) |-> $past(tk) || $past(tk, 2) || i2c_irq || $past(i2c_irq);
  endproperty
  a_rel: assert property (p_rel) else $error("stretch ended early");
  property p_wr; s_wtake |=> axi_rsp.bvalid && !axi_rsp.awready; endproperty
  a_wr: assert property (p_wr) else $error("no write answer");
  property p_rd; axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid; endproperty
  a_rd: assert property (p_rd) else $error("no read answer");
  property p_rdw; axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h0; endproperty
  a_rdw: assert property (p_rdw) else $error("read upper bits set");
endmodule // ist_checker

bind ist_slave ist_checker chk_i (.clk, .rst, .axi_req, .axi_rsp, .scl_i, .scl_o, .scl_oe_n,
  .sda_i, .sda_o, .sda_oe_n, .low_speed_clock, .i2c_irq);

// [verif/ist_master.sv]
module ist_master (
  input  wire logic clk,
  input  wire logic scl,
  input  wire logic sda,
  output      logic scl_oe_n,
  output      logic sda_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sc, sd;
  initial begin
    scl_oe_n = 1'b1;
    sda_oe_n = 1'b1;
  end
  // sample between edges so reads never race the slave
  always @(negedge clk) begin
    sc <= scl;
    sd <= sda;
  end
  task automatic hp();
    repeat (20) @(posedge clk);
  endtask
  task automatic bit_io(input logic b, output logic v);
    sda_oe_n <= b;
    hp();
    scl_oe_n <= 1'b1;
    @(posedge clk);
    while (sc !== 1'b1) @(posedge clk);
    hp();
    v = sd;
    scl_oe_n <= 1'b0;
    hp();
  endtask
  task automatic start();
    sda_oe_n <= 1'b0;
    hp();
    scl_oe_n <= 1'b0;
    hp();
  endtask
  task automatic stop();
    sda_oe_n <= 1'b0;
    hp();
    scl_oe_n <= 1'b1;
    hp();
    sda_oe_n <= 1'b1;
    hp();
  endtask
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a, k);
  endtask
endmodule // ist_master

// [verif/ist_slave_tb.sv]
`include "ist_map.svh"
module ist_slave_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ist_pkg::*;
  logic            clk = 1'b0, rst = 1'b1, lsc = 1'b0, irq_s, k;
  logic            scl_oe_n, sda_oe_n, m_scl_n, m_sda_n, scl_o, sda_o, i2c_irq;
  wire logic       scl = scl_oe_n & m_scl_n;
  wire logic       sda = sda_oe_n & m_sda_n;
  ist_axi_req_type req = '0;
  ist_axi_rsp_type rsp, rs;
  logic [31:0]     rnd = 32'h5fbdc58d;
  logic [7:0]      q, a, dt;
  logic [1:0]      r;
  int              n_mismatch = 0, checks = 0, cyc = 0, t0, n_irq = 0;
  always #5 clk = ~clk;
  always #37 lsc = ~lsc;
  always @(negedge clk) begin
    rs <= rsp;
    irq_s <= i2c_irq;
    if (i2c_irq === 1'b1) begin
      n_irq <= n_irq + 1;
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      complete_run();
    end
  end
  ist_slave dut (.clk(clk), .rst(rst), .axi_req(req), .axi_rsp(rsp), .scl_i(scl),
    .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .low_speed_clock(lsc), .i2c_irq(i2c_irq));
  ist_master mst (.clk(clk), .scl(scl), .sda(sda), .scl_oe_n(m_scl_n), .sda_oe_n(m_sda_n));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] v, input logic [1:0] er = 2'b00);
    @(posedge clk);
    req <= '{1'b1, ad, 1'b1, {24'h0, v}, 4'h1, 1'b1, 1'b0, 8'h0, 1'b0};
    do @(posedge clk); while (rs.awready !== 1'b1);
    req.awvalid <= 1'b0;
    req.wvalid <= 1'b0;
    do @(posedge clk); while (rs.bvalid !== 1'b1);
    req.bready <= 1'b0;
    chk(rs.bresp, er);
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge clk);
    req <= '{1'b0, 8'h0, 1'b0, 32'h0, 4'h0, 1'b0, 1'b1, ad, 1'b1};
    do @(posedge clk); while (rs.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge clk); while (rs.rvalid !== 1'b1);
    req.rready <= 1'b0;
    q = rs.rdata[7:0];
    r = rs.rresp;
  endtask
  task automatic rchk(input logic [7:0] ad, input logic [7:0] e);
    rd(ad);
    chk({r, q}, {2'b00, e});
  endtask
  task automatic complete_run();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rchk(`IST_OFS_TOC, 8'h00);
    rd(8'h14);
    chk({r, q}, 10'h200);
    wr(8'h14, 8'h5a, 2'b10);
    rnd = lfsr(rnd);
    a = {1'b0, rnd[6:0]};
    wr(`IST_OFS_ADDR, a);
    wr(`IST_OFS_CTRL0, 8'h01);
    $display("regs end");
    mst.start();
    mst.xfer({~a[6], a[5:0], 1'b1}, 1'b1, q, k);
    chk(k, 1'b1);
    mst.stop();
    mst.start();
    mst.xfer({a[6:0], 1'b0}, 1'b1, q, k);
    chk(k, 1'b0);
    rchk(`IST_OFS_CTRL1, 8'h60);
    chk(n_irq, 1);
    repeat (600) @(posedge clk);
    rchk(`IST_OFS_TOC, 8'h00);
    chk(scl_oe_n, 1'b0);
    rd(`IST_OFS_DATA);
    chk(scl_oe_n, 1'b1);
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      if (i == 2) wr(`IST_OFS_CTRL1, 8'h08);
      mst.xfer(rnd[7:0], 1'b1, q, k);
      chk(k, i == 2);
      rchk(`IST_OFS_DATA, rnd[7:0]);
    end
    mst.stop();
    rchk(`IST_OFS_CTRL1, 8'h08);
    chk(n_irq, 4);
    $display("write end");
    mst.start();
    mst.xfer({a[6:0], 1'b1}, 1'b1, q, k);
    chk(k, 1'b0);
    rchk(`IST_OFS_CTRL1, 8'h6c);
    wr(`IST_OFS_CTRL1, 8'h10);
    for (int i = 0; i < 2; i++) begin
      rnd = lfsr(rnd);
      wr(`IST_OFS_DATA, rnd[7:0]);
      mst.xfer(8'hff, i[0], q, k);
      chk(q, rnd[7:0]);
    end
    rchk(`IST_OFS_CTRL1, 8'h75);
    chk(n_irq, 7);
    chk(sda_oe_n, 1'b1);
    mst.stop();
    $display("read end");
    rnd = lfsr(rnd);
    dt = {6'h0, rnd[1:0]};
    wr(`IST_OFS_TOC, 8'h80 | dt);
    mst.start();
    mst.xfer({a[6:0], 1'b0}, 1'b1, q, k);
    t0 = cyc - 20;
    while (irq_s !== 1'b1) @(posedge clk);
    t0 = cyc - t0;
    chk(t0 >= (dt + 1) * 236 && t0 <= (dt + 1) * 237 + 20, 1'b1);
    rchk(`IST_OFS_TOC, 8'h40 | dt);
    chk(n_irq, 9);
    rchk(`IST_OFS_CTRL1, 8'h00);
    rchk(`IST_OFS_ADDR, a);
    rchk(`IST_OFS_CTRL0, 8'h01);
    chk(scl_oe_n, 1'b1);
    wr(`IST_OFS_TOC, 8'h40 | dt);
    rchk(`IST_OFS_TOC, 8'h40 | dt);
    wr(`IST_OFS_TOC, dt);
    rchk(`IST_OFS_TOC, dt);
    mst.stop();
    $display("timeout end");
    complete_run();
  end
endmodule // ist_slave_tb
